//--- pkg/hbg_pkg.sv
// Shared constants, types and register map of the line blanking generator.
package hbg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int POS_W  = 13;
  localparam int REP_W  = 8;
  localparam int DIV_W  = 3;
  localparam int ADDR_W = 8;
  localparam int SEQ_W  = 4;
  localparam int NUM_TOG = 6;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_HCLK_DIV = 8'h35;
  localparam int                DIV_LSB       = 4;
  localparam logic [ADDR_W-1:0] IDX_MASK      = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_ALT       = 8'h01;
  localparam logic [ADDR_W-1:0] IDX_EVEN1     = 8'h02;
  localparam logic [ADDR_W-1:0] IDX_LEN       = 8'h08;
  localparam logic [ADDR_W-1:0] IDX_REP       = 8'h09;
  localparam logic [ADDR_W-1:0] IDX_ODD1      = 8'h0A;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [POS_W-1:0] RST_POS  = 13'h1FFF;
  localparam logic [POS_W-1:0] RST_LEN  = 13'h0000;
  localparam logic [REP_W-1:0] RST_REP  = 8'h00;
  localparam logic [DIV_W-1:0] RST_DIV  = 3'h0;
  localparam logic             RST_MASK = 1'b0;

  // Alternation modes in code order 0 to 7.
  typedef enum logic [2:0] {
    HBG_ALT_ALL,
    HBG_ALT_ODD12,
    HBG_ALT_EVEN12,
    HBG_ALT_TWOSET,
    HBG_ALT_REP4,
    HBG_ALT_REP5,
    HBG_ALT_REP6,
    HBG_ALT_REP7
  } hbg_alt_e;

  typedef logic [NUM_TOG-1:0][POS_W-1:0] hbg_tog_t;

  // Blanking settings of one vertical sequence.
  typedef struct packed {
    logic             mask;
    hbg_alt_e         alt;
    hbg_tog_t         togEven;
    logic [POS_W-1:0] len;
    logic [REP_W-1:0] rep;
    hbg_tog_t         togOdd;
  } hbg_cfg_s;

  // Horizontal clock outputs.
  typedef struct packed {
    logic one;
    logic two;
    logic three;
    logic four;
    logic last;
  } hbg_hclk_s;

  // Register access request.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [SEQ_W-1:0]  seq;
    logic [ADDR_W-1:0] addr;
    logic [POS_W-1:0]  data;
  } hbg_reg_s;

endpackage : hbg_pkg

//--- verilog/hbg_line_blank.sv
// Horizontal blanking window and H-clock masking generator.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Up to six 13-bit toggle positions invert the blanking window per line.
// - Toggles three to six add extra pulse groups inside the blanking interval.
// - With width 0, clocks one, three and last follow the mask polarity bit during blanking.
// - Mode 0 uses all six even toggles on every line.
// - Mode 1: even toggles 1-2 on odd lines, 3-6 on even lines.
// - Mode 2: toggles 1-2 on even lines, 3-6 on odd lines.
// - Mode 3: six even toggles on even lines, six odd toggles on odd.
// - In mode 3 the odd set is read as odd-line toggles.
// - Modes 4-7 repeat a four-toggle pattern from start, end, length, repeats.
// - In modes 4-7 even toggle five is start, six is end.
// - 13-bit length and 8-bit repeat count matter only in modes 4-7.
// - Even toggles address pixels 0 to 8191; mode 3 uses them on even lines.
// - 3-bit clock width field sits at bits 6 to 4 of register 0x35.
// - Width 0 is full rate; 1-7 give 1/2 to 1/14 pixel frequency.
// - The reduced clock rate applies only inside the blanking area.
// - Width nonzero in modes 4-7 forces masks: one/three/last low, two/four high.
// - Each vertical sequence has its own blanking settings, chosen per line.
// - Clocks two and four are always complements of one and three.
// - No start polarity; only toggles mark blanking start and end.

module hbg_line_blank #(
  parameter int NUM_SEQ = 8
) (
  input  wire logic                     clk,         // Pixel clock.
  input  wire logic                     rstn,        // Synchronous reset, active low.
  input  wire hbg_pkg::hbg_reg_s        regReq,      // Register access request.
  output var  logic [hbg_pkg::POS_W-1:0] regRdata,   // Read data, one cycle after rd.
  input  wire logic [hbg_pkg::POS_W-1:0] pixelCount, // Pixel index within the line.
  input  wire logic                     lineStart,   // Pulse at pixel 0 of a line.
  input  wire logic                     fieldStart,  // Pulse at the first line of a field.
  input  wire logic [hbg_pkg::SEQ_W-1:0] seqSel,     // Active vertical sequence.
  input  wire logic                     hClkFull,    // Full-rate H-clock phase.
  output var  logic                     lineBlankWin, // Blanking window, high = blank.
  output var  hbg_pkg::hbg_hclk_s       hclk         // Horizontal clock levels.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    hbg_pkg::hbg_cfg_s [NUM_SEQ-1:0] cfg;
    logic [hbg_pkg::DIV_W-1:0]       hclkDiv;
    logic [hbg_pkg::SEQ_W-1:0]       actSeq;
    logic                            lineOdd;
    logic                            win;
    logic [hbg_pkg::POS_W-1:0]       patBase;
    logic [hbg_pkg::REP_W-1:0]       repCnt;
    logic                            patLive;
    logic [hbg_pkg::DIV_W-1:0]       divCnt;
    logic                            divLvl;
    hbg_pkg::hbg_hclk_s              hclk;
    logic [hbg_pkg::POS_W-1:0]       rdData;
  } hbg_state_s;

  hbg_state_s s_q;
  hbg_state_s s_d;

  // Hit when pos equals an enabled toggle; 8191 matches like any other position.
  function automatic logic togMatch(
    input logic [hbg_pkg::POS_W-1:0] pos,
    input hbg_pkg::hbg_tog_t         tog,
    input logic [hbg_pkg::NUM_TOG-1:0] en
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < hbg_pkg::NUM_TOG; i++)
    begin
      if (en[i] && tog[i] == pos)
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : togMatch

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  hbg_pkg::hbg_cfg_s                c;
  logic [hbg_pkg::SEQ_W-1:0]        seqNow;
  logic                             odd;
  logic                             winCur;
  logic                             repMode;
  logic [hbg_pkg::NUM_TOG-1:0]      togEn;
  hbg_pkg::hbg_tog_t                togSet;
  logic                             hit;
  logic                             inRange;
  logic [hbg_pkg::POS_W-1:0]        base;
  logic [hbg_pkg::POS_W-1:0]        offs;
  logic [hbg_pkg::REP_W-1:0]        repCur;
  logic                             live;
  logic                             rollOver;
  logic                             blanked;
  logic                             area;
  logic                             maskLvl;
  logic                             lvl;

  // Pattern decode and all register updates in one pass.
  always_comb
  begin
    s_d = s_q;
    // Register writes and reads; the width field is global.
    if (regReq.wr && regReq.addr == hbg_pkg::ADDR_HCLK_DIV)
    begin
      s_d.hclkDiv = regReq.data[hbg_pkg::DIV_LSB +: hbg_pkg::DIV_W];
    end
    else if (regReq.wr && 32'(regReq.seq) < NUM_SEQ)
    begin
      for (int i = 0; i < hbg_pkg::NUM_TOG; i++)
      begin
        if (regReq.addr == hbg_pkg::IDX_EVEN1 + 8'(i))
        begin
          s_d.cfg[regReq.seq].togEven[i] = regReq.data;
        end
        if (regReq.addr == hbg_pkg::IDX_ODD1 + 8'(i))
        begin
          s_d.cfg[regReq.seq].togOdd[i] = regReq.data;
        end
      end
      if (regReq.addr == hbg_pkg::IDX_MASK)
      begin
        s_d.cfg[regReq.seq].mask = regReq.data[0];
      end
      if (regReq.addr == hbg_pkg::IDX_ALT)
      begin
        s_d.cfg[regReq.seq].alt = hbg_pkg::hbg_alt_e'(regReq.data[2:0]);
      end
      if (regReq.addr == hbg_pkg::IDX_LEN)
      begin
        s_d.cfg[regReq.seq].len = regReq.data;
      end
      if (regReq.addr == hbg_pkg::IDX_REP)
      begin
        s_d.cfg[regReq.seq].rep = regReq.data[hbg_pkg::REP_W-1:0];
      end
    end
    s_d.rdData = '0;
    if (regReq.rd && regReq.addr == hbg_pkg::ADDR_HCLK_DIV)
    begin
      s_d.rdData[hbg_pkg::DIV_LSB +: hbg_pkg::DIV_W] = s_q.hclkDiv;
    end
    else if (regReq.rd && 32'(regReq.seq) < NUM_SEQ)
    begin
      for (int i = 0; i < hbg_pkg::NUM_TOG; i++)
      begin
        if (regReq.addr == hbg_pkg::IDX_EVEN1 + 8'(i))
        begin
          s_d.rdData = s_q.cfg[regReq.seq].togEven[i];
        end
        if (regReq.addr == hbg_pkg::IDX_ODD1 + 8'(i))
        begin
          s_d.rdData = s_q.cfg[regReq.seq].togOdd[i];
        end
      end
      if (regReq.addr == hbg_pkg::IDX_MASK)
      begin
        s_d.rdData[0] = s_q.cfg[regReq.seq].mask;
      end
      if (regReq.addr == hbg_pkg::IDX_ALT)
      begin
        s_d.rdData[2:0] = s_q.cfg[regReq.seq].alt;
      end
      if (regReq.addr == hbg_pkg::IDX_LEN)
      begin
        s_d.rdData = s_q.cfg[regReq.seq].len;
      end
      if (regReq.addr == hbg_pkg::IDX_REP)
      begin
        s_d.rdData[hbg_pkg::REP_W-1:0] = s_q.cfg[regReq.seq].rep;
      end
    end

    // Sequence, parity and pattern state are refreshed at each line start.
    seqNow = lineStart ? seqSel : s_q.actSeq;
    if (32'(seqNow) >= NUM_SEQ)
    begin
      seqNow = '0;
    end
    c       = s_q.cfg[seqNow];
    odd     = lineStart ? (!fieldStart && !s_q.lineOdd) : s_q.lineOdd;
    winCur  = lineStart ? 1'b0 : s_q.win;
    base    = lineStart ? c.togEven[4] : s_q.patBase;
    repCur  = lineStart ? '0 : s_q.repCnt;
    live    = lineStart ? 1'b1 : s_q.patLive;
    repMode = c.alt[2];
    s_d.actSeq  = seqNow;
    s_d.lineOdd = odd;

    // Toggle set selection for the alternation modes 0 to 3.
    togSet = c.togEven;
    unique case (c.alt)
      hbg_pkg::HBG_ALT_ALL:    togEn = 6'b11_1111;
      hbg_pkg::HBG_ALT_ODD12:  togEn = odd ? 6'b00_0011 : 6'b11_1100;
      hbg_pkg::HBG_ALT_EVEN12: togEn = odd ? 6'b11_1100 : 6'b00_0011;
      hbg_pkg::HBG_ALT_TWOSET:
      begin
        togEn = 6'b11_1111;
        if (odd)
        begin
          togSet = c.togOdd;
        end
      end
      default:                 togEn = 6'b00_1111;
    endcase

    // Repeated pattern: start, end, length and repeat count.
    inRange  = pixelCount >= c.togEven[4] && pixelCount < c.togEven[5];
    rollOver = live && c.len != '0 && pixelCount == base + c.len;
    if (rollOver)
    begin
      if (9'(repCur) + 9'd1 < 9'(c.rep))
      begin
        base   = pixelCount;
        repCur = repCur + 8'd1;
      end
      else
      begin
        live = 1'b0;
      end
    end
    offs = pixelCount - base;

    // Window inversion at each matching toggle.
    if (repMode)
    begin
      hit     = live && inRange && togMatch(offs, c.togEven, togEn);
      blanked = inRange && (winCur ^ hit);
      area    = inRange;
    end
    else
    begin
      hit     = togMatch(pixelCount, togSet, togEn);
      blanked = winCur ^ hit;
      area    = blanked;
    end
    s_d.win     = blanked;
    s_d.patBase = base;
    s_d.repCnt  = repCur;
    s_d.patLive = live;

    // Reduced-rate clock: toggles every div pixels inside the blanking area.
    if (area && s_q.hclkDiv != '0 && !lineStart)
    begin
      if (s_q.divCnt + 3'd1 >= s_q.hclkDiv)
      begin
        s_d.divCnt = '0;
        s_d.divLvl = !s_q.divLvl;
      end
      else
      begin
        s_d.divCnt = s_q.divCnt + 3'd1;
      end
    end
    else
    begin
      s_d.divCnt = '0;
      s_d.divLvl = 1'b0;
    end

    // Clock levels: hold at mask inside the pulse at width 0 or in modes 4-7, slow clock in the area.
    maskLvl = (repMode && s_q.hclkDiv != '0) ? 1'b0 : c.mask;
    if (blanked && (s_q.hclkDiv == '0 || repMode))
    begin
      lvl = maskLvl;
    end
    else if (area && s_q.hclkDiv != '0)
    begin
      lvl = s_q.divLvl;
    end
    else
    begin
      lvl = hClkFull;
    end
    s_d.hclk.one   = lvl;
    s_d.hclk.three = lvl;
    s_d.hclk.last  = lvl;
    s_d.hclk.two   = !lvl;
    s_d.hclk.four  = !lvl;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // State register with synchronous reset to defined defaults.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_SEQ; i++)
      begin
        s_q.cfg[i].mask    <= hbg_pkg::RST_MASK;
        s_q.cfg[i].alt     <= hbg_pkg::HBG_ALT_ALL;
        s_q.cfg[i].togEven <= {hbg_pkg::NUM_TOG{hbg_pkg::RST_POS}};
        s_q.cfg[i].len     <= hbg_pkg::RST_LEN;
        s_q.cfg[i].rep     <= hbg_pkg::RST_REP;
        s_q.cfg[i].togOdd  <= {hbg_pkg::NUM_TOG{hbg_pkg::RST_POS}};
      end
      s_q.hclkDiv <= hbg_pkg::RST_DIV;
      s_q.actSeq  <= '0;
      s_q.lineOdd <= 1'b0;
      s_q.win     <= 1'b0;
      s_q.patBase <= '0;
      s_q.repCnt  <= '0;
      s_q.patLive <= 1'b0;
      s_q.divCnt  <= '0;
      s_q.divLvl  <= 1'b0;
      s_q.hclk    <= 5'b0_1010;
      s_q.rdData  <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign lineBlankWin = s_q.win;
  assign hclk         = s_q.hclk;
  assign regRdata     = s_q.rdData;

endmodule : hbg_line_blank
`default_nettype wire

//--- dv/hbg_line_blank_sva.sv
// Assertions on the ports of the line blanking generator.
`timescale 1ns/1ps
`default_nettype none
module hbg_line_blank_sva (
  input wire logic               clk,          // Pixel clock.
  input wire logic               rstn,         // Reset, active low.
  input wire hbg_pkg::hbg_reg_s  regReq,       // Register request.
  input wire logic [12:0]        regRdata,     // Read data.
  input wire logic               lineStart,    // Line start pulse.
  input wire logic               hClkFull,     // Full-rate phase.
  input wire logic               lineBlankWin, // Blanking window.
  input wire hbg_pkg::hbg_hclk_s hclk          // Clock levels.
);
  logic [2:0] divQ;
  logic [2:0] divD;
  // Shadows the clock width field, since a divided clock may move inside blanking.
  always_comb
  begin
    divD = divQ;
    if (regReq.wr && regReq.addr == hbg_pkg::ADDR_HCLK_DIV)
      divD = regReq.data[6:4];
  end
  // Registers the shadow copy.
  always_ff @(posedge clk)
  begin
    divQ <= rstn ? divD : 3'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence sBlankRise; !lineBlankWin ##1 lineBlankWin; endsequence
  sequence sBlankStay; lineBlankWin ##1 lineBlankWin; endsequence
  sequence sDivWr; regReq.wr && regReq.addr == hbg_pkg::ADDR_HCLK_DIV; endsequence
  sequence sDivRd; regReq.rd && regReq.addr == hbg_pkg::ADDR_HCLK_DIV; endsequence
  a_two_comp: assert property (hclk.two == !hclk.one)
    else $error("clock two is not the inverse of clock one");
  a_four_comp: assert property (hclk.four == !hclk.three)
    else $error("clock four is not the inverse of clock three");
  a_mask_level: assert property (sBlankRise ##0 divQ == 3'h0 |->
    hclk.one == hclk.three && hclk.three == hclk.last)
    else $error("masked clocks differ in blanking");
  a_mask_hold: assert property (sBlankStay ##0 divQ == 3'h0 |-> $stable(hclk.one))
    else $error("masked clock moved in blanking");
  a_clock_pass: assert property ($past(rstn) && !lineBlankWin && divQ == 3'h0 |->
    hclk.one == $past(hClkFull) && hclk.last == $past(hClkFull))
    else $error("full-rate clock not passed outside blanking");
  a_line_clear: assert property (lineStart |=> !lineBlankWin)
    else $error("window not low at pixel zero");
  a_read_idle: assert property (!$past(regReq.rd) |-> regRdata == 13'h0000)
    else $error("read data not zero without a read");
  a_div_read: assert property (sDivWr ##1 sDivRd |=> regRdata[6:4] == divQ)
    else $error("width field read back wrong");
endmodule : hbg_line_blank_sva
bind hbg_line_blank hbg_line_blank_sva u_sva (.clk(clk), .rstn(rstn), .regReq(regReq),
  .regRdata(regRdata), .lineStart(lineStart), .hClkFull(hClkFull),
  .lineBlankWin(lineBlankWin), .hclk(hclk));
`default_nettype wire

//--- dv/hbg_ccd_hreg.sv
// Behavioural model of the sensor horizontal register.
`timescale 1ns/1ps
`default_nettype none
module hbg_ccd_hreg (
  input wire logic               clk,   // Pixel clock.
  input wire logic               rstn,  // Reset, active low.
  input wire hbg_pkg::hbg_hclk_s hclk,  // Horizontal clocks.
  output var int                 shifts // Stages moved.
);
  logic prevQ;
  // A rising phase one with phase two opposite moves the charge one stage.
  always_ff @(posedge clk)
  begin
    prevQ <= rstn ? hclk.one : 1'b0;
    shifts <= !rstn ? 0 : shifts + int'(hclk.one && !prevQ && hclk.two == !hclk.one);
  end
endmodule : hbg_ccd_hreg
`default_nettype wire

//--- dv/hbg_line_blank_tb.sv
// Self-checking testbench of the line blanking generator.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module hbg_line_blank_tb;
  typedef struct {int due; int kind; logic [12:0] val;} hbg_note_s;
  logic clk = 0, rstn = 0, lineStart = 0, fieldStart = 0, hClkFull = 0;
  logic lineBlankWin, odd, prevExp;
  logic [12:0] pixelCount = 0, regRdata, got;
  logic [12:0] te[2][6], to[2][6];
  logic [3:0] seqSel = 0;
  logic mk[2];
  hbg_pkg::hbg_reg_s regReq = '0;
  hbg_pkg::hbg_hclk_s hclk;
  hbg_note_s q[$], nt;
  int errors = 0, n_compared = 0, cyc = 0, shifts, expRises, s0, dv, md[2], rp[2];
  string nm[4] = '{"window", "clock one", "clock last", "read data"};
  hbg_line_blank dut (.clk(clk), .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
    .pixelCount(pixelCount), .lineStart(lineStart), .fieldStart(fieldStart),
    .seqSel(seqSel), .hClkFull(hClkFull), .lineBlankWin(lineBlankWin), .hclk(hclk));
  hbg_ccd_hreg u_ccd (.clk(clk), .rstn(rstn), .hclk(hclk), .shifts(shifts));
  // Makes the pixel clock and counts its rising edges.
  always #5 clk = ~clk;
  always @(posedge clk) cyc++;
  // Compares each due note with the settled outputs.
  always @(posedge clk)
  begin
    #1;
    while (q.size() > 0 && q[0].due <= cyc)
    begin
      nt = q.pop_front();
      got = nt.kind == 0 ? 13'(lineBlankWin) : nt.kind == 1 ? 13'(hclk.one) :
        nt.kind == 2 ? 13'(hclk.last) : regRdata;
      `CHK(nm[nt.kind], nt.val, got)
    end
  end
  task automatic note(int k, logic [12:0] v);
    q.push_back('{cyc + 1, k, v});
  endtask : note
  task automatic reg_op(bit w, bit r, int s, logic [7:0] a, logic [12:0] d, logic [12:0] e);
    @(negedge clk);
    regReq = '{w, r, 4'(s), a, d};
    if (r) note(3, e);
  endtask : reg_op
  task automatic idle(int n);
    @(negedge clk);
    regReq = '0;
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic prog(int s);
    reg_op(1, 0, s, 8'h00, 13'(mk[s]), 0);
    reg_op(1, 0, s, 8'h01, 13'(md[s]), 0);
    reg_op(1, 0, s, 8'h08, 13'h000A, 0);
    reg_op(1, 0, s, 8'h09, 13'(rp[s]), 0);
    for (int i = 0; i < 6; i++)
    begin
      reg_op(1, 0, s, 8'(2 + i), te[s][i], 0);
      reg_op(1, 0, s, 8'(10 + i), to[s][i], 0);
    end
  endtask : prog
  function automatic logic win_at(int s, int p);
    logic w;
    int o;
    w = 0;
    o = p - int'(te[s][4]);
    if (md[s] >= 4)
      return o >= 0 && p < te[s][5] && o / 10 < rp[s] && ((o % 10 >= te[s][0]) ^ (o % 10 >= te[s][1]));
    for (int i = 0; i < 6; i++)
      if ((md[s] == 0 || md[s] == 3 || (md[s] == 1) == (odd == (i < 2))) &&
          (odd && md[s] == 3 ? to[s][i] : te[s][i]) <= p)
        w = !w;
    return w;
  endfunction : win_at
  task automatic run_line(bit first);
    int s;
    logic w, one, slow;
    s = $urandom % 2;
    odd = first ? 1'b0 : !odd;
    for (int p = 0; p < 64; p++)
    begin
      @(negedge clk);
      pixelCount = 13'(p);
      lineStart = p == 0;
      fieldStart = first && p == 0;
      seqSel = p == 0 ? 4'(s) : 4'($urandom % 16);
      hClkFull = 1'($urandom);
      w = win_at(s, p);
      // Between pulses of the start-to-end area the clock runs divided, starting low.
      slow = md[s] >= 4 && dv != 0 && p >= int'(te[s][4]) && p < int'(te[s][5]);
      one = w ? (md[s] >= 4 && dv != 0 ? 1'b0 : mk[s]) :
        slow ? 1'(((p - int'(te[s][4])) / dv) % 2) : hClkFull;
      note(0, 13'(w));
      note(1, 13'(one));
      note(2, 13'(one));
      expRises += int'(one && !prevExp);
      prevExp = one;
    end
  endtask : run_line
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[FAIL] run length expected end seen hang");
    tally_and_finish();
  end
  // Resets the block, then checks registers and every alternation mode.
  initial
  begin
    void'($urandom(10013));
    repeat (10) @(negedge clk);
    rstn = 1;
    reg_op(0, 1, 0, 8'h02, 0, 13'h1FFF);
    reg_op(1, 0, 0, 8'h35, 13'h0070, 0);
    reg_op(0, 1, 0, 8'h35, 0, 13'h0070);
    reg_op(1, 0, 1, 8'h09, 13'h1FFF, 0);
    reg_op(0, 1, 1, 8'h09, 0, 13'h00FF);
    reg_op(1, 0, 0, 8'h01, 13'h1FFD, 0);
    reg_op(0, 1, 0, 8'h01, 0, 13'h0005);
    reg_op(0, 1, 0, 8'h20, 0, 13'h0000);
    reg_op(0, 1, 8, 8'h02, 0, 13'h0000);
    idle(2);
    $display("test registers done");
    for (int m = 0; m < 8; m++)
    begin
      dv = m < 4 ? 0 : m - 4;
      reg_op(1, 0, 0, 8'h35, 13'(dv << 4), 0);
      for (int s = 0; s < 2; s++)
      begin
        md[s] = m;
        mk[s] = 1'($urandom);
        rp[s] = 2 + s;
        for (int i = 0; i < 6; i++)
        begin
          te[s][i] = 13'(4 + 8 * i + $urandom % 6);
          to[s][i] = 13'(5 + 8 * i + $urandom % 6);
        end
        if (m >= 4) te[s] = '{13'h0002, 13'h0006, 13'h1FFF, 13'h1FFF, 13'h000A, s ? 13'h0022 : 13'h003C};
        prog(s);
      end
      idle(2);
      s0 = shifts;
      expRises = 0;
      prevExp = hClkFull;
      for (int l = 0; l < 3; l++) run_line(l == 0);
      idle(3);
      `CHK("shift count", expRises, shifts - s0)
      $display("test mode %0d done", m);
    end
    tally_and_finish();
  end
endmodule : hbg_line_blank_tb
`undef CHK
`default_nettype wire
